// >>> common/cqidx_pkg.sv
// Constants for the completion ring index block
package cqidx_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          STRB_W           = 4;
  localparam int          IDX_W            = 10;
  localparam int          OFF_W            = 13;

  // Register byte addresses
  localparam logic [7:0]  PROD_IDX_ADDR    = 8'hc8;
  localparam logic [7:0]  HIPR_PTRS_ADDR   = 8'hcc;
  localparam logic [7:0]  CTRL_ADDR        = 8'he0;
  localparam logic [7:0]  IRQ_STAT_ADDR    = 8'he4;
  localparam logic [7:0]  IRQ_MASK_ADDR    = 8'he8;

  // Field positions in the index registers
  localparam int          HI_IDX_LSB       = 16;
  localparam int          LO_IDX_LSB       = 0;
  localparam int          TWO_MODE_BIT     = 15;

  // Field positions in the control register
  localparam int          TX_WE_BIT        = 0;
  localparam int          ONE_WE_BIT       = 1;
  localparam int          TWO_WE_BIT       = 2;
  localparam int          LEVEL_LSB        = 4;
  localparam int          LEVEL_W          = 4;
  localparam int          TX_SIZE_BIT      = 8;
  localparam int          ONE_SIZE_BIT     = 9;
  localparam int          TWO_SIZE_BIT     = 10;
  localparam logic [31:0] CTRL_MASK        = 32'h0000_07f7;

  // Interrupt status bits
  localparam int          IRQ_W            = 4;
  localparam int          IRQ_TWO_LVL_BIT  = 0;
  localparam int          IRQ_TX_DONE_BIT  = 1;
  localparam int          IRQ_ONE_DONE_BIT = 2;
  localparam int          IRQ_TWO_DONE_BIT = 3;

  localparam logic [31:0] REG_RESET        = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_ONE     = 10'h001;
  localparam logic [IDX_W-1:0] IDX_MAX     = 10'h3ff;
  localparam int          LEVEL_SHIFT      = 2;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// >>> design/cqidx_axil.sv
// AXI4-Lite slave front end for the completion ring index block
module cqidx_axil
  import cqidx_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [STRB_W-1:0] i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic                   o_wr_en,
  output logic [ADDR_W-1:0]      o_wr_addr,
  output logic [DATA_W-1:0]      o_wr_data,
  output logic [STRB_W-1:0]      o_wr_strb,
  input  wire logic              i_wr_ok,
  output logic                   o_rd_en,
  output logic [ADDR_W-1:0]      o_rd_addr,
  input  wire logic [DATA_W-1:0] i_rd_data,
  input  wire logic              i_rd_ok
);
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [STRB_W-1:0] wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              awready_r;
  logic              wready_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;

  wire aw_take   = i_awvalid & awready_r;
  wire w_take    = i_wvalid & wready_r;
  // Both halves held and no response pending: commit the write
  wire wr_fire   = aw_hold_r & w_hold_r & ~bvalid_r;
  wire aw_hold_nxt = (aw_hold_r & ~wr_fire) | aw_take;
  wire w_hold_nxt  = (w_hold_r & ~wr_fire) | w_take;
  wire bvalid_nxt  = (bvalid_r & ~i_bready) | wr_fire;
  wire ar_take     = i_arvalid & arready_r;
  wire rvalid_nxt  = (rvalid_r & ~i_rready) | ar_take;

  assign o_wr_en   = wr_fire;
  assign o_wr_addr = awaddr_r;
  assign o_wr_data = wdata_r;
  assign o_wr_strb = wstrb_r;
  assign o_rd_en   = ar_take;
  assign o_rd_addr = i_araddr;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      if (aw_take) begin
        awaddr_r <= i_awaddr;
      end
      if (w_take) begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      bvalid_r  <= bvalid_nxt;
      if (wr_fire) begin
        bresp_r <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // Stall a second address until the pending write has answered
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= i_rd_ok ? i_rd_data : '0;
        rresp_r <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rresp   = rresp_r;
  assign o_rdata   = rdata_r;
endmodule

// >>> design/cqidx_top.sv
// Completion ring producer/consumer index bookkeeping with AXI4-Lite access
//
// Our own choice: the AXI4-Lite interface to the registers.
module cqidx_top
  import cqidx_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [STRB_W-1:0] i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              i_tx_done,
  input  wire logic              i_rx_one_done,
  input  wire logic              i_rx_two_done,
  output logic                   o_tx_ring_run,
  output logic                   o_rx_one_ring_run,
  output logic                   o_rx_two_ring_run,
  output logic [OFF_W-1:0]       o_tx_head_offset,
  output logic [OFF_W-1:0]       o_rx_one_head_offset,
  output logic [OFF_W-1:0]       o_rx_two_head_offset,
  output logic                   o_rx_two_empty,
  output logic                   o_rx_two_full,
  output logic                   o_irq
);
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Byte offset of an index for 4- or 8-byte entries
  function automatic logic [OFF_W-1:0] entry_offset(
      input logic [IDX_W-1:0] idx,
      input logic             wide);
    logic [OFF_W-1:0] ext;
    ext = {{(OFF_W-IDX_W){1'b0}}, idx};
    return wide ? (ext << 3) : (ext << 2);
  endfunction

  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  logic              wr_ok;

  logic [IDX_W-1:0]  tx_done_ring_head_r;
  logic [IDX_W-1:0]  rx_done_ring_one_head_r;
  logic [IDX_W-1:0]  rx_done_ring_two_head_r;
  logic [IDX_W-1:0]  rx_done_ring_two_tail_r;
  logic              rx_ring_two_threshold_select_r;
  logic [31:0]       ctrl_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic              irq_r;
  logic              tx_run_r;
  logic              one_run_r;
  logic              two_run_r;
  logic [OFF_W-1:0]  tx_off_r;
  logic [OFF_W-1:0]  one_off_r;
  logic [OFF_W-1:0]  two_off_r;
  logic              two_empty_r;
  logic              two_full_r;

  cqidx_axil u_axil (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_ok   (wr_ok),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );

  // Control fields
  wire tx_we    = ctrl_r[TX_WE_BIT];
  wire one_we   = ctrl_r[ONE_WE_BIT];
  wire two_we   = ctrl_r[TWO_WE_BIT];
  wire tx_wide  = ctrl_r[TX_SIZE_BIT];
  wire one_wide = ctrl_r[ONE_SIZE_BIT];
  wire two_wide = ctrl_r[TWO_SIZE_BIT];
  wire [LEVEL_W-1:0] rx_ring_two_level = ctrl_r[LEVEL_LSB +: LEVEL_W];

  // Address decode
  wire wr_prod = wr_en & (wr_addr == PROD_IDX_ADDR);
  wire wr_hipr = wr_en & (wr_addr == HIPR_PTRS_ADDR);
  wire wr_ctrl = wr_en & (wr_addr == CTRL_ADDR);
  wire wr_mask = wr_en & (wr_addr == IRQ_MASK_ADDR);
  wire wr_stat = wr_en & (wr_addr == IRQ_STAT_ADDR);
  assign wr_ok = wr_prod | wr_hipr | wr_ctrl | wr_mask | wr_stat;
  wire rd_stat = rd_en & (rd_addr == IRQ_STAT_ADDR);

  wire [31:0] prod_word = {6'h00, tx_done_ring_head_r, 6'h00,
                           rx_done_ring_one_head_r};
  wire [31:0] hipr_word = {6'h00, rx_done_ring_two_head_r,
                           rx_ring_two_threshold_select_r, 5'h00,
                           rx_done_ring_two_tail_r};
  wire [31:0] prod_wr   = merge_word(prod_word, wr_data, wr_strb);
  wire [31:0] hipr_wr   = merge_word(hipr_word, wr_data, wr_strb);
  wire [31:0] ctrl_wr   = merge_word(ctrl_r, wr_data, wr_strb) & CTRL_MASK;
  wire [31:0] mask_wr   = merge_word({{(32-IRQ_W){1'b0}}, irq_mask_r},
                                     wr_data, wr_strb);

  assign rd_ok = (rd_addr == PROD_IDX_ADDR) | (rd_addr == HIPR_PTRS_ADDR) |
                 (rd_addr == CTRL_ADDR) | (rd_addr == IRQ_STAT_ADDR) |
                 (rd_addr == IRQ_MASK_ADDR);
  assign rd_data =
      (rd_addr == PROD_IDX_ADDR)  ? prod_word :
      (rd_addr == HIPR_PTRS_ADDR) ? hipr_word :
      (rd_addr == CTRL_ADDR)      ? ctrl_r :
      (rd_addr == IRQ_STAT_ADDR)  ? {{(32-IRQ_W){1'b0}}, irq_stat_r} :
      (rd_addr == IRQ_MASK_ADDR)  ? {{(32-IRQ_W){1'b0}}, irq_mask_r} :
      32'h0000_0000;

  wire tx_inc  = i_tx_done & ~tx_we;
  wire one_inc = i_rx_one_done & ~one_we;
  wire two_inc = i_rx_two_done & ~two_we;

  wire [IDX_W-1:0] two_valid = rx_done_ring_two_head_r -
                               rx_done_ring_two_tail_r;
  // One slot always stays open, so usable space is one less than size
  wire [IDX_W-1:0] two_free  = IDX_MAX - two_valid;
  wire [IDX_W-1:0] two_level = {{(IDX_W-LEVEL_W){1'b0}},
                                rx_ring_two_level} << LEVEL_SHIFT;
  wire lvl_free  = two_free <= two_level;
  wire lvl_valid = two_valid >= two_level;
  wire two_lvl_hit = rx_ring_two_threshold_select_r ? lvl_valid : lvl_free;

  wire [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_TWO_LVL_BIT]  = two_lvl_hit;
  assign irq_events[IRQ_TX_DONE_BIT]  = tx_inc;
  assign irq_events[IRQ_ONE_DONE_BIT] = one_inc;
  assign irq_events[IRQ_TWO_DONE_BIT] = two_inc;
  // Read clears, but an event in the same cycle survives the clear
  wire [IRQ_W-1:0] irq_stat_nxt = (rd_stat ? '0 : irq_stat_r) | irq_events;

  // Transmit head
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_done_ring_head_r <= '0;
    end else if (wr_prod && tx_we) begin
      tx_done_ring_head_r <= prod_wr[HI_IDX_LSB +: IDX_W];
    end else if (tx_inc) begin
      tx_done_ring_head_r <= tx_done_ring_head_r + IDX_ONE;
    end
  end

  // Ring one head
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_done_ring_one_head_r <= '0;
    end else if (wr_prod && one_we) begin
      rx_done_ring_one_head_r <= prod_wr[LO_IDX_LSB +: IDX_W];
    end else if (one_inc) begin
      rx_done_ring_one_head_r <= rx_done_ring_one_head_r + IDX_ONE;
    end
  end

  // Ring two head
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_done_ring_two_head_r <= '0;
    end else if (wr_hipr && two_we) begin
      rx_done_ring_two_head_r <= hipr_wr[HI_IDX_LSB +: IDX_W];
    end else if (two_inc) begin
      rx_done_ring_two_head_r <= rx_done_ring_two_head_r + IDX_ONE;
    end
  end

  // Ring two tail, threshold mode, control and mask
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_done_ring_two_tail_r        <= '0;
      rx_ring_two_threshold_select_r <= 1'b0;
      ctrl_r                         <= REG_RESET;
      irq_mask_r                     <= '0;
    end else begin
      if (wr_hipr) begin
        rx_done_ring_two_tail_r        <= hipr_wr[LO_IDX_LSB +: IDX_W];
        rx_ring_two_threshold_select_r <= hipr_wr[TWO_MODE_BIT];
      end
      if (wr_ctrl) begin
        ctrl_r <= ctrl_wr;
      end
      if (wr_mask) begin
        irq_mask_r <= mask_wr[IRQ_W-1:0];
      end
    end
  end

  // Status, interrupt and registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_stat_r  <= '0;
      irq_r       <= 1'b0;
      tx_run_r    <= 1'b0;
      one_run_r   <= 1'b0;
      two_run_r   <= 1'b0;
      tx_off_r    <= '0;
      one_off_r   <= '0;
      two_off_r   <= '0;
      two_empty_r <= 1'b1;
      two_full_r  <= 1'b0;
    end else begin
      irq_stat_r  <= irq_stat_nxt;
      irq_r       <= |(irq_stat_nxt & irq_mask_r);
      tx_run_r    <= ~tx_we;
      one_run_r   <= ~one_we;
      two_run_r   <= ~two_we;
      tx_off_r    <= entry_offset(tx_done_ring_head_r, tx_wide);
      one_off_r   <= entry_offset(rx_done_ring_one_head_r, one_wide);
      two_off_r   <= entry_offset(rx_done_ring_two_head_r, two_wide);
      two_empty_r <= rx_done_ring_two_head_r == rx_done_ring_two_tail_r;
      two_full_r  <= (rx_done_ring_two_head_r + IDX_ONE) ==
                     rx_done_ring_two_tail_r;
    end
  end

  assign o_irq                = irq_r;
  assign o_tx_ring_run        = tx_run_r;
  assign o_rx_one_ring_run    = one_run_r;
  assign o_rx_two_ring_run    = two_run_r;
  assign o_tx_head_offset     = tx_off_r;
  assign o_rx_one_head_offset = one_off_r;
  assign o_rx_two_head_offset = two_off_r;
  assign o_rx_two_empty       = two_empty_r;
  assign o_rx_two_full        = two_full_r;
endmodule

// >>> tb/cqidx_checker.sv
// Concurrent checks on the completion ring index block ports
module cqidx_checker
  import cqidx_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  input wire logic             i_awvalid,
  input wire logic             i_wvalid,
  input wire logic             i_arvalid,
  input wire logic             i_bready,
  input wire logic             i_rready,
  input wire logic             i_tx_done,
  input wire logic             i_rx_two_done,
  input wire logic             o_awready,
  input wire logic             o_wready,
  input wire logic             o_arready,
  input wire logic             o_bvalid,
  input wire logic             o_rvalid,
  input wire logic             o_tx_ring_run,
  input wire logic             o_rx_two_ring_run,
  input wire logic [OFF_W-1:0] o_tx_head_offset,
  input wire logic             o_rx_two_empty,
  input wire logic             o_rx_two_full
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_ready_after_reset: assert property (!$past(i_rst_n) |=>
    o_awready && o_wready && o_arready && o_tx_ring_run)
    else $error("readies or run not up after reset");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
    o_wready |-> ##[1:4] o_bvalid) else $error("write not answered");
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("rvalid dropped early");
  // Run lags the enable one cycle, so it must still be up a cycle later
  a_tx_head_step: assert property (o_tx_ring_run && i_tx_done
    ##1 o_tx_ring_run |-> ##1
    o_tx_head_offset != $past(o_tx_head_offset, 2))
    else $error("tx head did not advance");
  a_two_leaves_empty: assert property (o_rx_two_ring_run &&
    i_rx_two_done && o_rx_two_empty ##1 o_rx_two_ring_run |->
    ##1 !o_rx_two_empty)
    else $error("ring two still empty after completion");
  a_empty_full_apart: assert property (!(o_rx_two_empty &&
    o_rx_two_full)) else $error("ring two empty and full at once");

  c_full: cover property (o_rx_two_full);
  c_slow_read: cover property (o_rvalid && !i_rready);
  c_refused_done: cover property (!o_tx_ring_run && i_tx_done);
endmodule

bind cqidx_top cqidx_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_arvalid(i_arvalid),
  .i_bready(i_bready), .i_rready(i_rready), .i_tx_done(i_tx_done),
  .i_rx_two_done(i_rx_two_done), .o_awready(o_awready),
  .o_wready(o_wready), .o_arready(o_arready), .o_bvalid(o_bvalid),
  .o_rvalid(o_rvalid), .o_tx_ring_run(o_tx_ring_run),
  .o_rx_two_ring_run(o_rx_two_ring_run),
  .o_tx_head_offset(o_tx_head_offset), .o_rx_two_empty(o_rx_two_empty),
  .o_rx_two_full(o_rx_two_full));

// >>> tb/cqidx_dma_model.sv
// Behavioural model of the host-side completion transfer engine
module cqidx_dma_model (
  input  wire logic       i_clk,
  output logic      [2:0] o_done
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_done = 3'h0;

  task automatic burst(input int ring, input int n, input int gap);
    repeat (n) begin
      @(posedge i_clk);
      o_done[ring] <= 1'b1;
      repeat (gap) begin
        @(posedge i_clk);
        o_done[ring] <= 1'b0;
      end
    end
    @(posedge i_clk);
    o_done[ring] <= 1'b0;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench for the completion ring index block
module tb_top
  import cqidx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic             arvalid = 1'b0, rready = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid, irq;
  logic             tx_run, one_run, two_run, empty, full;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [OFF_W-1:0] tx_off, one_off, two_off;
  logic [2:0]       done;
  int               n_errors = 0;
  int               cmp_count = 0;

  always #5 clk = ~clk;

  cqidx_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_tx_done(done[0]), .i_rx_one_done(done[1]),
    .i_rx_two_done(done[2]), .o_tx_ring_run(tx_run),
    .o_rx_one_ring_run(one_run), .o_rx_two_ring_run(two_run),
    .o_tx_head_offset(tx_off), .o_rx_one_head_offset(one_off),
    .o_rx_two_head_offset(two_off), .o_rx_two_empty(empty),
    .o_rx_two_full(full), .o_irq(irq));

  cqidx_dma_model dma (.i_clk(clk), .o_done(done));

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY, input int dl = 0);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_t && w_t));
    // Late bready exercises the held response
    tick(dl);
    bready <= 1'b1;
    do @(posedge clk); while (!(bready && bvalid));
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY, input int dl = 0);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    tick(dl);
    rready <= 1'b1;
    do @(posedge clk); while (!(rready && rvalid));
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic s_reset();
    rd(PROD_IDX_ADDR, 32'h0);
    rd(HIPR_PTRS_ADDR, 32'h0);
    rd(CTRL_ADDR, 32'h0);
    chk("run", 32'h7, {29'h0, tx_run, one_run, two_run});
    chk("empty", 32'h1, {31'h0, empty});
    chk("full_irq", 32'h0, {30'h0, full, irq});
  endtask

  task automatic s_tx();
    dma.burst(0, 3, 0);
    tick(3);
    chk("irq", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_ADDR, 32'h2);
    tick(2);
    chk("irq", 32'h1, {31'h0, irq});
    rd(PROD_IDX_ADDR, 32'h0003_0000);
    chk("tx_off", 32'hc, {19'h0, tx_off});
    rd(IRQ_STAT_ADDR, 32'h2);
    tick(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(CTRL_ADDR, 32'h100);
    tick(3);
    chk("tx_off", 32'h18, {19'h0, tx_off});
  endtask

  task automatic s_we();
    wr(CTRL_ADDR, 32'h1);
    tick(2);
    chk("tx_run", 32'h0, {31'h0, tx_run});
    dma.burst(0, 2, 0);
    tick(3);
    rd(IRQ_STAT_ADDR, 32'h0);
    wr(PROD_IDX_ADDR, 32'h03ff_0005);
    rd(PROD_IDX_ADDR, 32'h03ff_0000);
    wr(CTRL_ADDR, 32'h0);
    dma.burst(0, 1, 0);
    tick(3);
    rd(PROD_IDX_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'h2);
    wr(PROD_IDX_ADDR, 32'h0000_0005);
    wr(CTRL_ADDR, 32'h0);
    dma.burst(1, 2, 1);
    tick(3);
    rd(PROD_IDX_ADDR, 32'h7);
  endtask

  task automatic s_two();
    rd(IRQ_STAT_ADDR, 32'h6);
    dma.burst(2, 4, 1);
    tick(3);
    chk("empty", 32'h0, {31'h0, empty});
    wr(CTRL_ADDR, 32'h10);
    wr(HIPR_PTRS_ADDR, 32'h8000);
    rd(HIPR_PTRS_ADDR, 32'h0004_8000);
    rd(IRQ_STAT_ADDR, 32'h9);
    wr(HIPR_PTRS_ADDR, 32'h8001);
    rd(IRQ_STAT_ADDR, 32'h1);
    rd(IRQ_STAT_ADDR, 32'h0);
    wr(HIPR_PTRS_ADDR, 32'h0005);
    tick(3);
    chk("full", 32'h1, {31'h0, full});
    rd(IRQ_STAT_ADDR, 32'h1);
    rd(IRQ_STAT_ADDR, 32'h1);
    wr(HIPR_PTRS_ADDR, 32'h0004);
    tick(3);
    chk("empty", 32'h1, {31'h0, empty});
    wr(CTRL_ADDR, 32'h4);
    wr(HIPR_PTRS_ADDR, 32'h0010_0004);
    rd(HIPR_PTRS_ADDR, 32'h0010_0004);
    chk("two_run", 32'h0, {31'h0, two_run});
    wr(CTRL_ADDR, 32'h600);
    rd(CTRL_ADDR, 32'h600);
    chk("one_off", 32'h38, {19'h0, one_off});
    chk("two_off", 32'h80, {19'h0, two_off});
  endtask

  task automatic s_bus();
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h00, 32'h1, RESP_SLVERR);
    rd(IRQ_MASK_ADDR, 32'h2, RESP_OKAY, 3);
    wr(IRQ_MASK_ADDR, 32'h0, RESP_OKAY, 3);
  endtask

  initial begin
    tick(20);
    rst_n <= 1'b1;
    tick(2);
    s_reset();
    s_tx();
    s_we();
    s_two();
    s_bus();
    wrap_up();
  end

  // Whole run needs under two thousand cycles
  initial begin
    tick(5000);
    n_errors++;
    wrap_up();
  end
endmodule
